/* File: pkg/shift_logic_alu_pkg.sv */
package shift_logic_alu_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [4:0] acc_ofs = 5'h00;
    localparam logic [4:0] mem_ofs = 5'h04;
    localparam logic [4:0] imm_ofs = 5'h08;
    localparam logic [4:0] io_ofs = 5'h0c;
    localparam logic [4:0] flags_ofs = 5'h10;
    localparam logic [4:0] cmd_ofs = 5'h14;
    localparam logic [4:0] count_ofs = 5'h18;

    // ----------------------------------------
    // Flag fields and reset values
    // ----------------------------------------
    localparam int z_bit = 0;
    localparam int c_bit = 1;
    localparam int ac_bit = 2;
    localparam int ov_bit = 3;
    localparam logic [7:0] data_rst = 8'h00;
    localparam logic [3:0] flags_rst = 4'h0;

    // ----------------------------------------
    // Operation codes
    // ----------------------------------------
    typedef enum logic [4:0] {
        op_none = 5'h00,
        logical_right_shift_op_acc = 5'h01,
        op_rotr_acc = 5'h02,
        logical_right_shift_op_mem = 5'h03,
        op_rotr_mem = 5'h04,
        logical_left_shift_op_acc = 5'h05,
        op_rotl_acc = 5'h06,
        logical_left_shift_op_mem = 5'h07,
        op_rotl_mem = 5'h08,
        op_nibble_swap = 5'h09,
        op_and_imm = 5'h0a,
        op_and_mem = 5'h0b,
        op_and_to_mem = 5'h0c,
        op_or_imm = 5'h0d,
        op_or_mem = 5'h0e,
        op_or_to_mem = 5'h0f,
        op_xor_imm = 5'h10,
        op_xor_to_io = 5'h11,
        op_xor_mem = 5'h12,
        op_xor_to_mem = 5'h13,
        op_not_acc = 5'h14,
        op_not_mem = 5'h15,
        op_neg_acc = 5'h16,
        op_neg_mem = 5'h17
    } op_t;

endpackage : shift_logic_alu_pkg

/* File: verilog/shift_logic_alu.sv */
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module shift_logic_alu
    import shift_logic_alu_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] acc_q;
    logic [7:0] mem_q;
    logic [7:0] imm_q;
    logic [7:0] io_q;
    logic [3:0] flags_q;
    op_t last_op_q;
    logic [7:0] count_q;
    logic wait_q;
    logic [31:0] rdata_q;

    // ----------------------------------------
    // Bus access decode
    // ----------------------------------------
    // A request completes on the one edge where waitrequest is low.
    logic wr_ok;
    logic exec;
    op_t op_d;

    assign wr_ok = avs_write && !wait_q && avs_byteenable[0];
    assign exec = wr_ok && (avs_address == cmd_ofs);
    assign op_d = op_t'(avs_writedata[4:0]);

    // Waitrequest drops for one cycle per request, so every access takes
    // two cycles; this buys a registered read path at low cost.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((avs_read || avs_write) && wait_q);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && wait_q) begin
            if (avs_address == acc_ofs) begin
                rdata_q <= {24'h00_0000, acc_q};
            end else if (avs_address == mem_ofs) begin
                rdata_q <= {24'h00_0000, mem_q};
            end else if (avs_address == imm_ofs) begin
                rdata_q <= {24'h00_0000, imm_q};
            end else if (avs_address == io_ofs) begin
                rdata_q <= {24'h00_0000, io_q};
            end else if (avs_address == flags_ofs) begin
                rdata_q <= {28'h000_0000, flags_q};
            end else if (avs_address == cmd_ofs) begin
                rdata_q <= {27'h000_0000, last_op_q};
            end else if (avs_address == count_ofs) begin
                rdata_q <= {24'h00_0000, count_q};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    logic [7:0] res;
    logic to_acc;
    logic to_mem;
    logic to_io;
    logic c_we;
    logic c_new;
    logic z_we;
    logic cin;

    assign cin = flags_q[c_bit];

    always_comb begin
        res = 8'h00;
        to_acc = 1'b0;
        to_mem = 1'b0;
        to_io = 1'b0;
        c_we = 1'b0;
        c_new = cin;
        z_we = 1'b0;
        case (op_d)
            logical_right_shift_op_acc: begin
                res = {1'b0, acc_q[7:1]};
                c_new = acc_q[0];
                c_we = 1'b1;
                to_acc = 1'b1;
            end
            op_rotr_acc: begin
                res = {cin, acc_q[7:1]};
                c_new = acc_q[0];
                c_we = 1'b1;
                to_acc = 1'b1;
            end
            logical_right_shift_op_mem: begin
                res = {1'b0, mem_q[7:1]};
                c_new = mem_q[0];
                c_we = 1'b1;
                to_mem = 1'b1;
            end
            op_rotr_mem: begin
                res = {cin, mem_q[7:1]};
                c_new = mem_q[0];
                c_we = 1'b1;
                to_mem = 1'b1;
            end
            logical_left_shift_op_acc: begin
                res = {acc_q[6:0], 1'b0};
                c_new = acc_q[7];
                c_we = 1'b1;
                to_acc = 1'b1;
            end
            op_rotl_acc: begin
                res = {acc_q[6:0], cin};
                c_new = acc_q[7];
                c_we = 1'b1;
                to_acc = 1'b1;
            end
            logical_left_shift_op_mem: begin
                res = {mem_q[6:0], 1'b0};
                c_new = mem_q[7];
                c_we = 1'b1;
                to_mem = 1'b1;
            end
            op_rotl_mem: begin
                res = {mem_q[6:0], cin};
                c_new = mem_q[7];
                c_we = 1'b1;
                to_mem = 1'b1;
            end
            op_nibble_swap: begin
                res = {acc_q[3:0], acc_q[7:4]};
                to_acc = 1'b1;
            end
            op_and_imm, op_and_mem: begin
                res = acc_q & ((op_d == op_and_imm) ? imm_q : mem_q);
                z_we = 1'b1;
                to_acc = 1'b1;
            end
            op_and_to_mem: begin
                res = acc_q & mem_q;
                z_we = 1'b1;
                to_mem = 1'b1;
            end
            op_or_imm, op_or_mem: begin
                res = acc_q | ((op_d == op_or_imm) ? imm_q : mem_q);
                z_we = 1'b1;
                to_acc = 1'b1;
            end
            op_or_to_mem: begin
                res = acc_q | mem_q;
                z_we = 1'b1;
                to_mem = 1'b1;
            end
            op_xor_imm: begin
                res = acc_q ^ imm_q;
                z_we = 1'b1;
                to_acc = 1'b1;
            end
            op_xor_to_io: begin
                res = acc_q ^ io_q;
                to_io = 1'b1;
            end
            op_xor_mem, op_xor_to_mem: begin
                res = acc_q ^ mem_q;
                z_we = 1'b1;
                to_acc = (op_d == op_xor_mem);
                to_mem = (op_d == op_xor_to_mem);
            end
            op_not_acc: begin
                res = ~acc_q;
                z_we = 1'b1;
                to_acc = 1'b1;
            end
            op_not_mem: begin
                res = ~mem_q;
                z_we = 1'b1;
                to_mem = 1'b1;
            end
            op_neg_acc: begin
                res = 8'h00 - acc_q;
                z_we = 1'b1;
                to_acc = 1'b1;
            end
            op_neg_mem: begin
                res = 8'h00 - mem_q;
                z_we = 1'b1;
                to_mem = 1'b1;
            end
            default: begin
                res = 8'h00;
            end
        endcase
    end

    // ----------------------------------------
    // Operand and result registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_q <= data_rst;
        end else if (exec && to_acc) begin
            acc_q <= res;
        end else if (wr_ok && avs_address == acc_ofs) begin
            acc_q <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_q <= data_rst;
        end else if (exec && to_mem) begin
            mem_q <= res;
        end else if (wr_ok && avs_address == mem_ofs) begin
            mem_q <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            imm_q <= data_rst;
        end else if (wr_ok && avs_address == imm_ofs) begin
            imm_q <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            io_q <= data_rst;
        end else if (exec && to_io) begin
            io_q <= res;
        end else if (wr_ok && avs_address == io_ofs) begin
            io_q <= avs_writedata[7:0];
        end
    end

    // ----------------------------------------
    // Flags
    // ----------------------------------------
    // AC and OV are only ever written by software here; the arithmetic
    // that moves them lives outside this slice.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags_q <= flags_rst;
        end else if (exec) begin
            if (c_we) begin
                flags_q[c_bit] <= c_new;
            end
            if (z_we) begin
                flags_q[z_bit] <= (res == 8'h00);
            end
        end else if (wr_ok && avs_address == flags_ofs) begin
            flags_q <= avs_writedata[3:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_op_q <= op_none;
            count_q <= data_rst;
        end else if (exec) begin
            last_op_q <= op_d;
            count_q <= count_q + 8'h01;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    op_t chk_op_q;
    logic chk_exec_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chk_op_q <= op_none;
            chk_exec_q <= 1'b0;
        end else begin
            chk_op_q <= op_d;
            chk_exec_q <= exec;
        end
    end

    acc_right_shift_a: assert property (@(posedge clk_sys) disable iff (rst)
        exec && op_d == logical_right_shift_op_acc |=> acc_q == {1'b0, $past(acc_q[7:1])}
        && flags_q == {$past(flags_q[3:2]), $past(acc_q[0]), $past(flags_q[0])})
        else $error("acc right shift wrong");
    acc_rotate_right_a: assert property (@(posedge clk_sys) disable iff (rst)
        exec && op_d == op_rotr_acc |=> acc_q == {$past(cin), $past(acc_q[7:1])}
        && cin == $past(acc_q[0]))
        else $error("acc rotate right wrong");
    mem_right_shift_a: assert property (@(posedge clk_sys) disable iff (rst)
        exec && op_d == logical_right_shift_op_mem |=> mem_q == {1'b0, $past(mem_q[7:1])}
        && cin == $past(mem_q[0]) && $stable(acc_q))
        else $error("mem right shift wrong");
    mem_rotate_right_a: assert property (@(posedge clk_sys) disable iff (rst)
        exec && op_d == op_rotr_mem |=> mem_q == {$past(cin), $past(mem_q[7:1])})
        else $error("mem rotate right wrong");
    acc_left_shift_a: assert property (@(posedge clk_sys) disable iff (rst)
        exec && op_d == logical_left_shift_op_acc |=> acc_q == {$past(acc_q[6:0]), 1'b0}
        && cin == $past(acc_q[7]))
        else $error("acc left shift wrong");
    acc_rotate_left_a: assert property (@(posedge clk_sys) disable iff (rst)
        exec && op_d == op_rotl_acc |=> acc_q == {$past(acc_q[6:0]), $past(cin)})
        else $error("acc rotate left wrong");
    mem_left_shift_a: assert property (@(posedge clk_sys) disable iff (rst)
        exec && op_d == logical_left_shift_op_mem |=> mem_q == {$past(mem_q[6:0]), 1'b0}
        && cin == $past(mem_q[7]))
        else $error("mem left shift wrong");
    mem_rotate_left_a: assert property (@(posedge clk_sys) disable iff (rst)
        exec && op_d == op_rotl_mem |=> mem_q == {$past(mem_q[6:0]), $past(cin)})
        else $error("mem rotate left wrong");
    nibble_swap_a: assert property (@(posedge clk_sys) disable iff (rst)
        exec && op_d == op_nibble_swap |=> acc_q == {$past(acc_q[3:0]), $past(acc_q[7:4])}
        && $stable(flags_q))
        else $error("nibble swap wrong");
    xor_io_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
        exec && op_d == op_xor_to_io |=> io_q == ($past(acc_q) ^ $past(io_q))
        && $stable(flags_q))
        else $error("io xor wrong");
    neg_acc_a: assert property (@(posedge clk_sys) disable iff (rst)
        exec && op_d == op_neg_acc |=> acc_q + $past(acc_q) == 8'h00)
        else $error("acc negate wrong");
    zero_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        chk_exec_q && chk_op_q inside {op_and_imm, op_and_mem, op_or_imm, op_or_mem, op_xor_imm,
        op_xor_mem, op_not_acc, op_neg_acc} |-> flags_q[z_bit] == (acc_q == 8'h00)
        && flags_q[3:1] == $past(flags_q[3:1]))
        else $error("zero flag wrong");
    wait_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
        !wait_q |=> wait_q)
        else $error("waitrequest low too long");

endmodule : shift_logic_alu

/* File: sim/shift_logic_alu_bench.sv */
`timescale 1ns/1ps
module shift_logic_alu_bench;
    import shift_logic_alu_pkg::*;

    // ----------------------------------------
    // Stimulus and observation signals
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int errors = 0;
    int num_checks = 0;
    logic [7:0] ea, em, ei, eo;
    logic [7:0] ecnt = 8'h00;
    logic [3:0] ef;
    logic [4:0] opc;
    logic [31:0] rd;

    always #25 clk_sys = ~clk_sys;

    shift_logic_alu shift_logic_alu_i (
        .clk_sys(clk_sys),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ----------------------------------------
    // Avalon-MM master
    // ----------------------------------------
    // The request is held until waitrequest is seen low at a rising edge.
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= ~wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        // A lost answer is counted and the run goes on, so the verdict has one exit.
        if (avs_waitrequest !== 1'b0) begin
            errors++;
            $display("[ERR] %0t ns: no bus answer", $time);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // Upper lanes carry noise so that only the low byte may matter.
    task wr(input logic [4:0] a, input logic [7:0] v);
        bus(1'b1, a, {24'($urandom), v}, 4'hf);
    endtask : wr

    task rdc(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000, 4'hf);
        check(rd, exp);
    endtask : rdc

    // ----------------------------------------
    // Expected results
    // ----------------------------------------
    function automatic logic [8:0] rsh(input logic [7:0] v, input logic cin);
        return {v[0], cin, v[7:1]};
    endfunction : rsh

    function automatic logic [8:0] lsh(input logic [7:0] v, input logic cin);
        return {v[7], v[6:0], cin};
    endfunction : lsh

    function void model(input logic [4:0] op);
        ecnt = ecnt + 8'h01;
        case (op)
            logical_right_shift_op_acc: {ef[c_bit], ea} = rsh(ea, 1'b0);
            op_rotr_acc: {ef[c_bit], ea} = rsh(ea, ef[c_bit]);
            logical_right_shift_op_mem: {ef[c_bit], em} = rsh(em, 1'b0);
            op_rotr_mem: {ef[c_bit], em} = rsh(em, ef[c_bit]);
            logical_left_shift_op_acc: {ef[c_bit], ea} = lsh(ea, 1'b0);
            op_rotl_acc: {ef[c_bit], ea} = lsh(ea, ef[c_bit]);
            logical_left_shift_op_mem: {ef[c_bit], em} = lsh(em, 1'b0);
            op_rotl_mem: {ef[c_bit], em} = lsh(em, ef[c_bit]);
            op_nibble_swap: ea = {ea[3:0], ea[7:4]};
            op_and_imm: ea = ea & ei;
            op_and_mem: ea = ea & em;
            op_and_to_mem: em = ea & em;
            op_or_imm: ea = ea | ei;
            op_or_mem: ea = ea | em;
            op_or_to_mem: em = ea | em;
            op_xor_imm: ea = ea ^ ei;
            op_xor_to_io: eo = ea ^ eo;
            op_xor_mem: ea = ea ^ em;
            op_xor_to_mem: em = ea ^ em;
            op_not_acc: ea = ~ea;
            op_not_mem: em = ~em;
            op_neg_acc: ea = 8'h00 - ea;
            op_neg_mem: em = 8'h00 - em;
            default: ;
        endcase
        if (op inside {op_and_to_mem, op_or_to_mem, op_xor_to_mem, op_not_mem, op_neg_mem}) begin
            ef[z_bit] = (em == 8'h00);
        end else if (op inside {[op_and_imm:op_xor_imm], op_xor_mem, op_not_acc, op_neg_acc}) begin
            ef[z_bit] = (ea == 8'h00);
        end
    endfunction : model

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(63020));
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            rdc(5'(k * 4), 32'h00000000);
        end
        // Opcode 0x1f is not defined; it must count and read back from cmd but change no data register or flag.
        for (int op = 1; op < 25; op++) begin
            opc = (op == 24) ? 5'h1f : 5'(op);
            for (int it = 0; it < 6; it++) begin
                if (it == 0) begin
                    {ea, em, ei, eo, ef} = {8'h38, 8'h38, 8'h00, 8'h38, 4'he};
                end else if (it == 1) begin
                    {ea, em, ei, eo, ef} = {8'h80, 8'h80, 8'hff, 8'h80, 4'h1};
                end else begin
                    {ea, em, ei, eo, ef} = 36'($urandom) ^ {32'($urandom), 4'h0};
                end
                wr(acc_ofs, ea);
                wr(mem_ofs, em);
                wr(imm_ofs, ei);
                wr(io_ofs, eo);
                wr(flags_ofs, {4'h0, ef});
                wr(cmd_ofs, {3'h0, opc});
                model(opc);
                rdc(acc_ofs, {24'h0, ea});
                rdc(mem_ofs, {24'h0, em});
                rdc(io_ofs, {24'h0, eo});
                rdc(flags_ofs, {28'h0, ef});
                rdc(imm_ofs, {24'h0, ei});
                rdc(cmd_ofs, {27'h0, opc});
                rdc(count_ofs, {24'h0, ecnt});
            end
        end
        // Worked values: 0x38 inverts to 0xc7 and negates to 0xc8.
        wr(acc_ofs, 8'h38);
        wr(cmd_ofs, {3'h0, op_not_acc});
        rdc(acc_ofs, 32'h000000c7);
        wr(acc_ofs, 8'h38);
        wr(cmd_ofs, {3'h0, op_neg_acc});
        rdc(acc_ofs, 32'h000000c8);
        // A write without lane 0 enabled must leave the register alone.
        bus(1'b1, acc_ofs, 32'h00000055, 4'he);
        rdc(acc_ofs, 32'h000000c8);
        rdc(5'h1c, 32'h00000000);
        wrap_up();
    end
endmodule : shift_logic_alu_bench
